// File: src/rtc_ctrl_pkg.sv
// How it works
// - ten-bit signed trim at bits 25:16
// - positive trim adds that many pulses
// - negative trim removes pulses, minimum code 512
// - enable bit 15 runs the unit
// - enable writable only when unlock reads one
// - idle-halt bit 13 gates bus clock
// - bit 7 selects seconds clock or alarm
// - pin drives only when bit 0 set
// - bit 6 shows clock running
// - unlock settable only under system unlock
// - half-second clears on seconds write
// - register reset only by power-on reset
// - unimplemented bits read zero, ignore writes
package rtc_ctrl_pkg;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] TIME_OFFSET   = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam int TRIM_LSB     = 16;
  localparam int TRIM_MSB     = 25;
  localparam int ENABLE_BIT   = 15;
  localparam int IDLE_BIT     = 13;
  localparam int SRC_BIT      = 7;
  localparam int RUN_BIT      = 6;
  localparam int UNLOCK_BIT   = 3;
  localparam int SYNC_BIT     = 2;
  localparam int HALF_BIT     = 1;
  localparam int OE_BIT       = 0;
  localparam int SEC_LSB      = 8;
  localparam int SEC_MSB      = 14;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h03FF_A089;
  localparam logic [31:0] TIME_WMASK = 32'h0000_7F00;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int SYNC_WINDOW        = 32;
  typedef struct packed {
    logic [9:0] trim;
    logic       enable;
    logic       idle_halt;
    logic       pin_source_select;
    logic       time_write_unlock;
    logic       pin_output_enable;
  } ctrl_t;
  typedef struct packed {
    logic [6:0] seconds;
    logic       half_second_flag;
    logic       seconds_tick;
    logic       minute_tick;
  } time_t;
endpackage

// File: src/calendar_clock_control.sv
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module calendar_clock_control #(
  parameter int unsigned NOMINAL_HALF = 16384
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        por_rst,
  input  wire logic        rtc_clk_pin,
  input  wire logic        idle_mode,
  input  wire logic        sys_write_unlock,
  input  wire logic        alarm_pulse,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             rtc_pin_out,
  output logic             rtc_pin_oe,
  output logic             bus_clk_gate,
  output logic             seconds_clock
);
  import rtc_ctrl_pkg::*;

  // por_rst alone resets control state; sys_rst only clears bus/pin staging
  ctrl_t       ctrl, next_ctrl;
  time_t       tm, next_tm;
  logic [2:0]  rtc_sync, next_rtc_sync;
  logic        running, next_running;
  logic [15:0] sub_cnt, next_sub_cnt;
  logic [15:0] half_len, next_half_len;
  logic [5:0]  sec_in_min, next_sec_in_min;
  logic        pready_q, next_pready;
  logic [31:0] prdata_q, next_prdata;
  logic        pslverr_q, next_pslverr;
  logic        pin_q, next_pin;
  logic        oe_q, next_oe;
  logic        gate_q, next_gate;
  logic        secclk_q, next_secclk;
  logic        acc, acc_end, wr_ctrl, wr_time;
  logic        rtc_edge, sync_flag, last_sec;

  function automatic logic [15:0] trimmed_half(input logic [9:0] t);
    logic [15:0] base;
    base = 16'(NOMINAL_HALF);
    // negative trim shortens the minute, positive lengthens it
    if (t[9])
      trimmed_half = base - 16'({6'h00, (~t) + 10'h001});
    else
      trimmed_half = base + 16'({6'h00, t});
  endfunction

  assign acc      = psel && penable && !pready_q;
  // writes land on the edge where the master sees pready, not before
  assign acc_end  = psel && penable && pready_q;
  assign wr_ctrl  = acc_end && pwrite && paddr == CTRL_OFFSET;
  assign wr_time  = acc_end && pwrite && paddr == TIME_OFFSET;
  assign rtc_edge = rtc_sync[1] && !rtc_sync[2];
  assign last_sec = sec_in_min == 6'(SECONDS_PER_MINUTE - 1);
  // adding rather than subtracting keeps short half seconds from wrapping
  assign sync_flag = running && sub_cnt + 16'(SYNC_WINDOW) >= half_len
                     && tm.half_second_flag;

  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.trim              = pwdata[TRIM_MSB:TRIM_LSB];
      next_ctrl.idle_halt         = pwdata[IDLE_BIT];
      next_ctrl.pin_source_select = pwdata[SRC_BIT];
      next_ctrl.pin_output_enable = pwdata[OE_BIT];
      if (ctrl.time_write_unlock)
        next_ctrl.enable = pwdata[ENABLE_BIT];
      next_ctrl.time_write_unlock =
        pwdata[UNLOCK_BIT] && (sys_write_unlock || ctrl.time_write_unlock);
    end
  end

  always_comb begin
    next_rtc_sync   = {rtc_sync[1:0], rtc_clk_pin};
    next_tm         = tm;
    next_tm.seconds_tick = 1'b0;
    next_tm.minute_tick  = 1'b0;
    next_running    = ctrl.enable;
    next_sub_cnt    = sub_cnt;
    next_half_len   = half_len;
    next_sec_in_min = sec_in_min;
    if (!ctrl.enable) begin
      next_sub_cnt = 16'h0000;
    end else if (rtc_edge) begin
      if (sub_cnt + 16'h0001 >= half_len) begin
        next_sub_cnt = 16'h0000;
        next_tm.half_second_flag = !tm.half_second_flag;
        if (tm.half_second_flag) begin
          next_tm.seconds_tick = 1'b1;
          if (last_sec) begin
            next_sec_in_min     = 6'h00;
            next_tm.minute_tick = 1'b1;
            next_tm.seconds     = 7'h00;
          end else begin
            next_sec_in_min = sec_in_min + 6'h01;
            next_tm.seconds = tm.seconds + 7'h01;
          end
        end
        // only the first half second after a minute rolls is reshaped
        if (tm.half_second_flag && last_sec)
          next_half_len = trimmed_half(ctrl.trim);
        else
          next_half_len = 16'(NOMINAL_HALF);
      end else begin
        next_sub_cnt = sub_cnt + 16'h0001;
      end
    end
    if (wr_time) begin
      next_tm.seconds          = pwdata[SEC_MSB:SEC_LSB];
      next_tm.half_second_flag = 1'b0;
      next_sub_cnt             = 16'h0000;
      // minute position follows the written seconds; no range check above 59
      next_sec_in_min          = pwdata[SEC_LSB+5:SEC_LSB];
      next_half_len            = 16'(NOMINAL_HALF);
    end
  end

  always_comb begin
    next_pready  = acc;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (acc) begin
      case (paddr)
        CTRL_OFFSET: begin
          next_prdata[TRIM_MSB:TRIM_LSB] = ctrl.trim;
          next_prdata[ENABLE_BIT]        = ctrl.enable;
          next_prdata[IDLE_BIT]          = ctrl.idle_halt;
          next_prdata[SRC_BIT]           = ctrl.pin_source_select;
          next_prdata[RUN_BIT]           = running;
          next_prdata[UNLOCK_BIT]        = ctrl.time_write_unlock;
          next_prdata[SYNC_BIT]          = sync_flag;
          next_prdata[HALF_BIT]          = tm.half_second_flag;
          next_prdata[OE_BIT]            = ctrl.pin_output_enable;
        end
        TIME_OFFSET: next_prdata[SEC_MSB:SEC_LSB] = tm.seconds;
        STATUS_OFFSET: next_prdata[5:0] = sec_in_min;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_comb begin
    next_secclk = tm.half_second_flag;
    next_oe     = ctrl.pin_output_enable;
    if (!ctrl.pin_output_enable)
      next_pin = 1'b0;
    else if (ctrl.pin_source_select)
      next_pin = tm.half_second_flag;
    else
      next_pin = alarm_pulse;
    next_gate = !(ctrl.idle_halt && idle_mode);
  end

  // only power-on reset reaches the control register and time keeping
  always_ff @(posedge sys_clk) begin
    if (por_rst)
      ctrl <= ctrl_t'(0);
    else
      ctrl <= next_ctrl;
  end

  // a system reset must not disturb the count, so the sync stays here too
  always_ff @(posedge sys_clk) begin
    if (por_rst) begin
      rtc_sync   <= 3'h0;
      tm         <= time_t'(0);
      running    <= 1'b0;
      sub_cnt    <= 16'h0000;
      half_len   <= 16'(NOMINAL_HALF);
      sec_in_min <= 6'h00;
    end else begin
      rtc_sync   <= next_rtc_sync;
      tm         <= next_tm;
      running    <= next_running;
      sub_cnt    <= next_sub_cnt;
      half_len   <= next_half_len;
      sec_in_min <= next_sec_in_min;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || por_rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= next_pready;
      prdata_q  <= next_prdata;
      pslverr_q <= next_pslverr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || por_rst) begin
      pin_q     <= 1'b0;
      oe_q      <= 1'b0;
      gate_q    <= 1'b1;
      secclk_q  <= 1'b0;
    end else begin
      pin_q     <= next_pin;
      oe_q      <= next_oe;
      gate_q    <= next_gate;
      secclk_q  <= next_secclk;
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign rtc_pin_out   = pin_q;
  assign rtc_pin_oe    = oe_q;
  assign bus_clk_gate  = gate_q;
  assign seconds_clock = secclk_q;
endmodule

// File: bench/calendar_clock_control_chk.sv
`timescale 1ns/100ps
module calendar_clock_control_chk (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        por_rst,
  input wire logic        idle_mode,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rtc_pin_out,
  input wire logic        rtc_pin_oe,
  input wire logic        bus_clk_gate
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst || por_rst);
  sequence s_acc; psel && penable && !pready; endsequence
  a_ready_next: assert property (s_acc |=> pready)
    else $error("access not answered");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready without access");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  a_pin_quiet: assert property (!rtc_pin_oe |-> !rtc_pin_out)
    else $error("pin driven while off");
  // a write lands on the pready edge and the pin flop follows one edge later
  a_oe_by_write: assert property ($changed(rtc_pin_oe) |->
    $past(pready, 2) || $past(sys_rst || por_rst) ||
    $past(sys_rst || por_rst, 2))
    else $error("pin enable moved alone");
  a_gate_run: assert property (!idle_mode |=> bus_clk_gate)
    else $error("bus clock gated outside idle");
  a_gate_stop: assert property (!bus_clk_gate |-> $past(idle_mode))
    else $error("gate without idle");
endmodule
bind calendar_clock_control calendar_clock_control_chk
  i_calendar_clock_control_chk (.sys_clk, .sys_rst, .por_rst, .idle_mode,
  .psel, .penable, .pready, .prdata, .pslverr, .rtc_pin_out, .rtc_pin_oe,
  .bus_clk_gate);

// File: bench/calendar_clock_control_bench.sv
`timescale 1ns/100ps
module calendar_clock_control_bench;
  import rtc_ctrl_pkg::*;
  typedef struct packed {
    logic        u;
    logic [11:0] a;
    logic [31:0] d, m, x;
    logic        e;
  } row_t;
  logic        sys_clk = 0, sys_rst = 1, por_rst = 1, rtc_clk_pin = 0;
  logic        idle_mode = 0, sys_write_unlock = 0, alarm_pulse = 0;
  logic        psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic        pready, pslverr, rtc_pin_out, rtc_pin_oe;
  logic        bus_clk_gate, seconds_clock;
  int          n_errors = 0, checked = 0, cyc = 0, n;
  int          tr[2] = '{3, -3};
  logic [31:0] pv[4] = '{32'h1, 32'h81, 32'h2000, 32'h0};
  row_t        rows[6] = '{
    '{1'b0, 12'h000, 32'hFFFFFFFF, 32'hFFFFFFB9, 32'h03FF2081, 1'b0},
    '{1'b0, 12'h00C, 32'h1, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h000, 32'h8, 32'hFFFFFFB9, 32'h8, 1'b0},
    '{1'b0, 12'h000, 32'h8008, 32'hFFFFFFF9, 32'h8048, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'hFFFFFFF9, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h3B00, 32'h7F00, 32'h3B00, 1'b0}};
  calendar_clock_control #(.NOMINAL_HALF(8)) i_calendar_clock_control (
    .sys_clk, .sys_rst, .por_rst, .rtc_clk_pin, .idle_mode,
    .sys_write_unlock, .alarm_pulse, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .rtc_pin_out, .rtc_pin_oe,
    .bus_clk_gate, .seconds_clock);
  initial forever #5 sys_clk = ~sys_clk;
  task test_done;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the bench timeout ends a hung access
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // counts rtc_clk_pin pulses until the half-second output flips
  task half(output int c);
    logic s;
    s = seconds_clock;
    c = 0;
    while (seconds_clock === s && c < 40) begin
      rtc_clk_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rtc_clk_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      c++;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd & 32'hFFFFFFB9, CTRL_RESET);
    foreach (rows[i]) begin
      sys_write_unlock <= rows[i].u;
      apb(1'b1, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd & rows[i].m, rows[i].x);
    end
    $display("register rows done");
    idle_mode <= 1'b1;
    alarm_pulse <= 1'b1;
    foreach (pv[i]) begin
      apb(1'b1, CTRL_OFFSET, pv[i]);
      repeat (2) @(posedge sys_clk);
      chk(rtc_pin_out, pv[i] == 32'h1);
      chk(rtc_pin_oe, pv[i][0]);
      chk(bus_clk_gate, !pv[i][13]);
    end
    $display("pin and idle done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CTRL_OFFSET, 32'h81);
      sys_rst <= i == 0;
      por_rst <= i == 1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd & 32'hFFFFFFB9, i ? CTRL_RESET : 32'h81);
    end
    $display("reset kinds done");
    sys_write_unlock <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h8);
    foreach (tr[i]) begin
      apb(1'b1, CTRL_OFFSET, {6'h00, 10'(tr[i]), 16'h8008});
      apb(1'b1, TIME_OFFSET, 32'h3B00);
      @(posedge sys_clk);
      chk(seconds_clock, 1'b0);
      repeat (3) half(n);
      chk(n, 8 + tr[i]);
    end
    $display("trim done");
    test_done();
  end
endmodule
